//--- rtl/tcp_pkg.sv
// Package with offsets, field positions and reset values for the timer block
package tcp_pkg;
    localparam int          ADDR_W     = 4;
    localparam logic [3:0]  ADR_CR2    = 4'h0;
    localparam logic [3:0]  ADR_CR1    = 4'h1;
    localparam logic [3:0]  ADR_SR     = 4'h2;
    localparam logic [3:0]  ADR_IC1H   = 4'h3;
    localparam logic [3:0]  ADR_IC1L   = 4'h4;
    localparam logic [3:0]  ADR_OC1H   = 4'h5;
    localparam logic [3:0]  ADR_OC1L   = 4'h6;
    localparam logic [3:0]  ADR_CNTH   = 4'h7;
    localparam logic [3:0]  ADR_CNTL   = 4'h8;
    localparam logic [3:0]  ADR_IC2H   = 4'h9;
    localparam logic [3:0]  ADR_IC2L   = 4'hA;
    localparam logic [3:0]  ADR_OC2H   = 4'hB;
    localparam logic [3:0]  ADR_OC2L   = 4'hC;
    // Control 1 fields
    localparam int          C1_CAPTURE_IRQ_ENABLE    = 7;
    localparam int          C1_COMPARE_IRQ_ENABLE    = 6;
    localparam int          C1_TOIE    = 5;
    localparam int          C1_FOLV2   = 4;
    localparam int          C1_FOLV1   = 3;
    localparam int          C1_OLVL2   = 2;
    localparam int          C1_IEDG1   = 1;
    localparam int          C1_OLVL1   = 0;
    // Control 2 fields
    localparam int          C2_OC1E    = 7;
    localparam int          C2_OC2E    = 6;
    localparam int          C2_OPM     = 5;
    localparam int          C2_PWM     = 4;
    localparam int          C2_CC_LSB  = 2;
    localparam int          C2_IEDG2   = 1;
    localparam int          C2_EXEDG   = 0;
    // Status fields
    localparam int          SR_FIRST_CAPTURE_FLAG    = 7;
    localparam int          SR_OCF1    = 6;
    localparam int          SR_TOF     = 5;
    localparam int          SR_SECOND_CAPTURE_FLAG    = 4;
    localparam int          SR_OCF2    = 3;
    localparam logic [7:0]  SR_MASK    = 8'hF8;
    // Reset, reload and wrap values
    localparam logic [7:0]  CR_RST     = 8'h00;
    localparam logic [15:0] CNT_RST    = 16'hFFFC;
    localparam logic [15:0] RELOAD_VAL = 16'hFFFC;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] OC_RST     = 16'hFFFF;
    // Prescale select and terminal counts
    localparam logic [1:0]  CC_DIV4    = 2'h0;
    localparam logic [1:0]  CC_DIV2    = 2'h1;
    localparam logic [1:0]  CC_DIV8    = 2'h2;
    localparam logic [1:0]  CC_EXT     = 2'h3;
    localparam logic [2:0]  TERM_DIV2  = 3'h1;
    localparam logic [2:0]  TERM_DIV4  = 3'h3;
    localparam logic [2:0]  TERM_DIV8  = 3'h7;
endpackage : tcp_pkg

//--- rtl/tcp_prescaler.sv
// Counter tick generator: CPU clock divider or external clock edge
`timescale 1ns/100ps
module tcp_prescaler (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] prescale_select,
    input  wire logic       ext_clk,
    input  wire logic       ext_rising,
    output logic            tick
);
    import tcp_pkg::*;

    logic [2:0] div_q;
    logic [2:0] term;
    logic       ext_prev_q;

    always_comb begin
        unique case (prescale_select)
            CC_DIV2: term = TERM_DIV2;
            CC_DIV8: term = TERM_DIV8;
            default: term = TERM_DIV4;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_q <= 3'h0;
        end else if (div_q >= term) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= ext_clk;
        end
    end

    always_comb begin
        if (prescale_select == CC_EXT) begin
            tick = ext_rising ? (ext_clk & ~ext_prev_q) : (~ext_clk & ext_prev_q);
        end else begin
            tick = (div_q >= term);
        end
    end

    a_div2_rate: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && prescale_select == CC_DIV2) ##1 (prescale_select == CC_DIV2) |-> !tick)
        else $error("divide by two ticked on adjacent cycles");
endmodule : tcp_prescaler

//--- rtl/tcp_compare_chan.sv
// One compare channel: value bytes, high-byte interlock, match detect
`timescale 1ns/100ps
module tcp_compare_chan (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        wr_high,
    input  wire logic        wr_low,
    input  wire logic [7:0]  wdata,
    input  wire logic [15:0] count,
    output logic [15:0]      compare_value,
    output logic             match
);
    import tcp_pkg::*;

    logic [15:0] value_q;
    logic        inhibit_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            value_q <= OC_RST;
        end else if (wr_high) begin
            value_q[15:8] <= wdata;
        end else if (wr_low) begin
            value_q[7:0] <= wdata;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            inhibit_q <= 1'b0;
        end else if (wr_high) begin
            inhibit_q <= 1'b1;
        end else if (wr_low) begin
            inhibit_q <= 1'b0;
        end
    end

    assign compare_value = value_q;
    assign match         = ~inhibit_q & ~wr_high & (count == value_q);
endmodule : tcp_compare_chan

//--- rtl/tcp_top.sv
// Summary of operation
// - Sixteen-bit free-running counter advanced by prescaler or external clock.
// - Prescaler divides CPU clock by 2, 4 or 8 per two-bit field.
// - Overflow flag with a maskable interrupt request.
// - Two compare channels, each with value bytes, flag and maskable interrupt.
// - Each timer instance owns all its state; instances share nothing and count independently.
// - Unbonded input pins read as constant one.
// - Compare flag clears after status read then low byte access.
// - Writing the high compare byte suspends matching until low byte write.
// - Flag and pin level apply while counter equals compare value.
// - Disabled pin stays undriven; interrupt may still be raised.
// - Force bit copies level to pin without flag or interrupt.
// - Force bits ignored in one-pulse or PWM mode.
// - PWM with levels 1 then 0 gives positive pulse between compares.
// - PWM with equal levels holds first pin constant.
// - PWM second-channel match reloads counter with FFFC.
// - PWM never sets compare flags.
// - PWM second match sets first capture flag and may interrupt.
// - PWM disconnects first capture pin; second capture still works.
// - PWM and one-pulse both set means PWM only.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module tcp_top #(
    parameter bit FIRST_CAP_BONDED  = 1'b1,
    parameter bit SECOND_CAP_BONDED = 1'b1,
    parameter bit EXT_CLK_BONDED    = 1'b1
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic [tcp_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]            wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic [7:0]                 rdata_q,
    input  wire logic                  first_capture_pin,
    input  wire logic                  second_capture_pin,
    input  wire logic                  external_timer_clock_pin,
    output logic [1:0]                 compare_output_pin_q,
    output logic [1:0]                 compare_output_oe_q,
    output logic                       timer_irq_q
);
    import tcp_pkg::*;

    logic [7:0]  cr1_q;
    logic [7:0]  cr2_q;
    logic [7:0]  sr_q;
    logic [7:0]  arm_q;
    logic [7:0]  sr_set;
    logic [7:0]  sr_acc;
    logic [7:0]  sr_clr;
    logic [15:0] cnt_q;
    logic [15:0] ic1_q;
    logic [15:0] ic2_q;
    logic [15:0] oc1_val;
    logic [15:0] oc2_val;
    logic        m1;
    logic        m2;
    logic        tick;
    logic        cap1_in;
    logic        cap2_in;
    logic        ext_in;
    logic        cap1_prev_q;
    logic        cap2_prev_q;
    logic        cap1_edge;
    logic        cap2_edge;
    logic        pwm_on;
    logic        opm_on;
    logic        force_wr;
    logic        cnt_wrap;

    // Unbonded pins read high
    assign cap1_in = FIRST_CAP_BONDED  ? first_capture_pin        : 1'b1;
    assign cap2_in = SECOND_CAP_BONDED ? second_capture_pin       : 1'b1;
    assign ext_in  = EXT_CLK_BONDED    ? external_timer_clock_pin : 1'b1;

    assign pwm_on = cr2_q[C2_PWM];
    assign opm_on = cr2_q[C2_OPM] & ~cr2_q[C2_PWM];
    assign cnt_wrap = tick & (cnt_q == CNT_MAX) & ~(pwm_on & m2) & ~(opm_on & cap1_edge);

    tcp_prescaler u_presc (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .prescale_select (cr2_q[C2_CC_LSB +: 2]),
        .ext_clk         (ext_in),
        .ext_rising      (cr2_q[C2_EXEDG]),
        .tick            (tick)
    );

    tcp_compare_chan u_oc1 (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .wr_high       (wr && addr == ADR_OC1H),
        .wr_low        (wr && addr == ADR_OC1L),
        .wdata         (wdata),
        .count         (cnt_q),
        .compare_value (oc1_val),
        .match         (m1)
    );

    tcp_compare_chan u_oc2 (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .wr_high       (wr && addr == ADR_OC2H),
        .wr_low        (wr && addr == ADR_OC2L),
        .wdata         (wdata),
        .count         (cnt_q),
        .compare_value (oc2_val),
        .match         (m2)
    );

    // Control registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cr1_q <= CR_RST;
            cr2_q <= CR_RST;
        end else if (wr && addr == ADR_CR1) begin
            cr1_q <= wdata;
        end else if (wr && addr == ADR_CR2) begin
            cr2_q <= wdata;
        end
    end

    // Capture edge detect
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cap1_prev_q <= 1'b1;
            cap2_prev_q <= 1'b1;
        end else begin
            cap1_prev_q <= cap1_in;
            cap2_prev_q <= cap2_in;
        end
    end

    assign cap1_edge = ~pwm_on & (cr1_q[C1_IEDG1] ? (cap1_in & ~cap1_prev_q)
                                                  : (~cap1_in & cap1_prev_q));
    assign cap2_edge = cr2_q[C2_IEDG2] ? (cap2_in & ~cap2_prev_q)
                                       : (~cap2_in & cap2_prev_q);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ic1_q <= 16'h0000;
        end else if (cap1_edge) begin
            ic1_q <= cnt_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ic2_q <= 16'h0000;
        end else if (cap2_edge) begin
            ic2_q <= cnt_q;
        end
    end

    // Free-running counter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= CNT_RST;
        end else if (pwm_on && tick && m2) begin
            cnt_q <= RELOAD_VAL;
        end else if (opm_on && cap1_edge) begin
            cnt_q <= RELOAD_VAL;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Status flag events and two-step clear
    always_comb begin
        sr_set           = 8'h00;
        sr_set[SR_FIRST_CAPTURE_FLAG]  = cap1_edge | (pwm_on & m2);
        sr_set[SR_OCF1]  = ~pwm_on & m1;
        sr_set[SR_TOF]   = cnt_wrap;
        sr_set[SR_SECOND_CAPTURE_FLAG]  = cap2_edge;
        sr_set[SR_OCF2]  = ~pwm_on & m2;
        sr_acc           = 8'h00;
        sr_acc[SR_FIRST_CAPTURE_FLAG]  = rd & (addr == ADR_IC1L);
        sr_acc[SR_OCF1]  = (rd | wr) & (addr == ADR_OC1L);
        sr_acc[SR_TOF]   = (rd | wr) & (addr == ADR_CNTL);
        sr_acc[SR_SECOND_CAPTURE_FLAG]  = rd & (addr == ADR_IC2L);
        sr_acc[SR_OCF2]  = (rd | wr) & (addr == ADR_OC2L);
        sr_clr           = arm_q & sr_acc;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sr_q <= 8'h00;
        end else begin
            sr_q <= ((sr_q & ~sr_clr) | sr_set) & SR_MASK;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arm_q <= 8'h00;
        end else if (rd && addr == ADR_SR) begin
            arm_q <= sr_q;
        end else begin
            arm_q <= arm_q & ~sr_clr;
        end
    end

    // Compare output pins
    assign force_wr = wr && addr == ADR_CR1 && !opm_on && !pwm_on;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            compare_output_pin_q[0] <= 1'b0;
        end else if (!cr2_q[C2_OC1E]) begin
            compare_output_pin_q[0] <= compare_output_pin_q[0];
        end else if (pwm_on) begin
            if (m2) begin
                compare_output_pin_q[0] <= cr1_q[C1_OLVL2];
            end else if (m1) begin
                compare_output_pin_q[0] <= cr1_q[C1_OLVL1];
            end
        end else if (opm_on) begin
            if (cap1_edge) begin
                compare_output_pin_q[0] <= cr1_q[C1_OLVL2];
            end else if (m1) begin
                compare_output_pin_q[0] <= cr1_q[C1_OLVL1];
            end
        end else if (force_wr && wdata[C1_FOLV1]) begin
            compare_output_pin_q[0] <= wdata[C1_OLVL1];
        end else if (m1) begin
            compare_output_pin_q[0] <= cr1_q[C1_OLVL1];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            compare_output_pin_q[1] <= 1'b0;
        end else if (!cr2_q[C2_OC2E] || pwm_on) begin
            compare_output_pin_q[1] <= compare_output_pin_q[1];
        end else if (force_wr && wdata[C1_FOLV2]) begin
            compare_output_pin_q[1] <= wdata[C1_OLVL2];
        end else if (m2) begin
            compare_output_pin_q[1] <= cr1_q[C1_OLVL2];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            compare_output_oe_q <= 2'b00;
        end else begin
            compare_output_oe_q <= {cr2_q[C2_OC2E], cr2_q[C2_OC1E]};
        end
    end

    // Interrupt request, CPU mask applied outside
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timer_irq_q <= 1'b0;
        end else begin
            timer_irq_q <= (cr1_q[C1_TOIE] & sr_q[SR_TOF])
                         | (cr1_q[C1_COMPARE_IRQ_ENABLE] & (sr_q[SR_OCF1] | sr_q[SR_OCF2]))
                         | (cr1_q[C1_CAPTURE_IRQ_ENABLE] & (sr_q[SR_FIRST_CAPTURE_FLAG] | sr_q[SR_SECOND_CAPTURE_FLAG]));
        end
    end

    // Register read port, data one cycle after strobe
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd) begin
            unique case (addr)
                ADR_CR2:  rdata_q <= cr2_q;
                ADR_CR1:  rdata_q <= cr1_q & ~8'h18;
                ADR_SR:   rdata_q <= sr_q;
                ADR_IC1H: rdata_q <= ic1_q[15:8];
                ADR_IC1L: rdata_q <= ic1_q[7:0];
                ADR_OC1H: rdata_q <= oc1_val[15:8];
                ADR_OC1L: rdata_q <= oc1_val[7:0];
                ADR_CNTH: rdata_q <= cnt_q[15:8];
                ADR_CNTL: rdata_q <= cnt_q[7:0];
                ADR_IC2H: rdata_q <= ic2_q[15:8];
                ADR_IC2L: rdata_q <= ic2_q[7:0];
                ADR_OC2H: rdata_q <= oc2_val[15:8];
                ADR_OC2L: rdata_q <= oc2_val[7:0];
                default:  rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    a_pwm_no_ocf: assert property (@(posedge clk_sys) disable iff (rst)
        (pwm_on && !sr_q[SR_OCF1] && !(wr && addr == ADR_CR2)) |=> !sr_q[SR_OCF1])
        else $error("compare flag set in PWM mode");

    a_pwm_reload: assert property (@(posedge clk_sys) disable iff (rst)
        (pwm_on && tick && m2) |=> (cnt_q == RELOAD_VAL))
        else $error("PWM reload value wrong");

    a_pwm_capflag: assert property (@(posedge clk_sys) disable iff (rst)
        (pwm_on && m2) |=> sr_q[SR_FIRST_CAPTURE_FLAG])
        else $error("first capture flag not set on PWM period end");

    a_match_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (!pwm_on && m1 && !(wr && addr == ADR_OC1L))
        |=> (sr_q[SR_OCF1] && $past(cnt_q) == oc1_val))
        else $error("compare flag missing on match");

    a_high_inhibit: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == ADR_OC1H) ##1 !(wr && addr == ADR_OC1L) |-> !m1)
        else $error("match after high byte write");

    a_flag_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (rd && addr == ADR_SR && sr_q[SR_OCF1]) ##[1:2]
        ((rd || wr) && addr == ADR_OC1L && !m1 && !pwm_on) ##1 !m1 |-> !sr_q[SR_OCF1])
        else $error("compare flag not cleared by sequence");

    a_tof_wrap: assert property (@(posedge clk_sys) disable iff (rst)
        (tick && cnt_q == CNT_MAX && !(pwm_on && m2) && !(opm_on && cap1_edge))
        |=> (sr_q[SR_TOF] && cnt_q == 16'h0000))
        else $error("overflow flag not set on wrap");

    a_force_level: assert property (@(posedge clk_sys) disable iff (rst)
        (force_wr && wdata[C1_FOLV1] && cr2_q[C2_OC1E] && !sr_q[SR_OCF1] && !m1)
        |=> (compare_output_pin_q[0] == $past(wdata[C1_OLVL1]) && !sr_q[SR_OCF1]))
        else $error("forced level not copied to pin");

    a_pwm_no_ocf2: assert property (@(posedge clk_sys) disable iff (rst)
        (pwm_on && !sr_q[SR_OCF2] && !(wr && addr == ADR_CR2)) |=> !sr_q[SR_OCF2])
        else $error("second compare flag set in PWM mode");

    a_mode_force: assert property (@(posedge clk_sys) disable iff (rst)
        (wr && addr == ADR_CR1 && (cr2_q[C2_PWM] || cr2_q[C2_OPM]) && !m1 && !m2 && !cap1_edge)
        |=> $stable(compare_output_pin_q))
        else $error("force bit acted in a timed mode");

    a_pwm_cap1_off: assert property (@(posedge clk_sys) disable iff (rst)
        pwm_on |=> $stable(ic1_q))
        else $error("first capture register loaded in PWM mode");

    a_both_modes: assert property (@(posedge clk_sys) disable iff (rst)
        (cr2_q[C2_PWM] && cr2_q[C2_OPM] && !tick) |=> $stable(cnt_q))
        else $error("one-pulse reload acted in PWM mode");

    a_cap_irq: assert property (@(posedge clk_sys) disable iff (rst)
        (cr1_q[C1_CAPTURE_IRQ_ENABLE] && sr_q[SR_FIRST_CAPTURE_FLAG]) |=> timer_irq_q)
        else $error("capture interrupt not raised");

    a_pin_disabled: assert property (@(posedge clk_sys) disable iff (rst)
        !cr2_q[C2_OC1E] |=> $stable(compare_output_pin_q[0]))
        else $error("disabled compare pin changed");
endmodule : tcp_top

//--- bench/tcp_pin_model.sv
// Far-side pin model: external count clock and two capture inputs
`timescale 1ns/100ps
module tcp_pin_model (
    input  wire logic clk_sys,
    output logic      ext_clk,
    output logic      cap1,
    output logic      cap2
);
    initial begin
        ext_clk = 1'b0;
        cap1    = 1'b1;
        cap2    = 1'b1;
    end

    // Clock stands low between bursts; four CPU clocks per phase
    task automatic clock_edges(input int n);
        repeat (2 * n) begin
            repeat (4) @(posedge clk_sys);
            ext_clk <= ~ext_clk;
        end
    endtask : clock_edges

    // One low pulse on a capture pin, idle level high
    task automatic capture_pulse(input bit second);
        @(posedge clk_sys);
        if (second) cap2 <= 1'b0;
        else cap1 <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cap1 <= 1'b1;
        cap2 <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : capture_pulse
endmodule : tcp_pin_model

//--- bench/test_timer16_compare_pwm.sv
// Self-checking bench for the timer compare and pulse-width block
`timescale 1ns/100ps
module test_timer16_compare_pwm;
    import tcp_pkg::*;
    typedef struct packed {
        logic [3:0] a;
        logic [7:0] e;
    } tcp_row_t;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic [3:0]  addr    = 4'h0;
    logic [7:0]  wdata   = 8'h00;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [7:0]  rdata_q;
    logic        ext_clk;
    logic        cap1;
    logic        cap2;
    logic [1:0]  pin_q;
    logic [1:0]  oe_q;
    logic        irq_q;
    int          num_errors = 0;
    int          compares   = 0;
    int          cycles     = 0;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [15:0] c;
    logic [15:0] t;
    logic [1:0]  sel [3] = '{CC_DIV2, CC_DIV4, CC_DIV8};
    logic [7:0]  step [3] = '{8'h08, 8'h04, 8'h02};
    tcp_row_t    rows [11] = '{'{ADR_SR, 8'h00}, '{ADR_CR2, 8'h00}, '{ADR_CR1, 8'h00},
        '{ADR_OC1H, 8'hFF}, '{ADR_OC1L, 8'hFF}, '{ADR_OC2H, 8'hFF}, '{ADR_OC2L, 8'hFF},
        '{ADR_IC1H, 8'h00}, '{ADR_IC2L, 8'h00}, '{4'hD, 8'h00}, '{4'hF, 8'h00}};

    always #5 clk_sys = ~clk_sys;

    tcp_top tcp_top_i (
        .clk_sys                  (clk_sys),
        .rst                      (rst),
        .addr                     (addr),
        .wdata                    (wdata),
        .wr                       (wr),
        .rd                       (rd),
        .rdata_q                  (rdata_q),
        .first_capture_pin        (cap1),
        .second_capture_pin       (cap2),
        .external_timer_clock_pin (ext_clk),
        .compare_output_pin_q     (pin_q),
        .compare_output_oe_q      (oe_q),
        .timer_irq_q              (irq_q)
    );

    tcp_pin_model tcp_pin_model_i (
        .clk_sys (clk_sys),
        .ext_clk (ext_clk),
        .cap1    (cap1),
        .cap2    (cap2)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 v = rdata_q;
    endtask : rd_reg

    task automatic get_cnt(output logic [15:0] v);
        logic [7:0] h;
        logic [7:0] l;
        rd_reg(ADR_CNTH, h);
        rd_reg(ADR_CNTL, l);
        v = {h, l};
    endtask : get_cnt

    task automatic ext_ticks(input int n);
        tcp_pin_model_i.clock_edges(n);
        repeat (3) @(posedge clk_sys);
    endtask : ext_ticks

    task automatic wr_cmp(input logic [3:0] ah, input logic [15:0] v);
        wr_reg(ah, v[15:8]);
        wr_reg(ah + 4'h1, v[7:0]);
    endtask : wr_cmp

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // Hang guard: the whole sequence needs a few hundred cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            $display("ERROR timeout expected finish seen hang");
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (rows[i]) begin
            rd_reg(rows[i].a, d);
            chk("reset value", rows[i].e, d);
        end
        $display("Test reset values done");
        // Counter starts near the top, so wrap and the top compare both occur
        repeat (8) @(posedge clk_sys);
        rd_reg(ADR_SR, d);
        chk("status after wrap", 8'h68, d & SR_MASK);
        rd_reg(ADR_CNTL, d);
        rd_reg(ADR_OC1L, d);
        rd_reg(ADR_OC2L, d);
        rd_reg(ADR_SR, d);
        chk("status cleared", 8'h00, d & SR_MASK);
        $display("Test overflow done");
        foreach (sel[i]) begin
            wr_reg(ADR_CR2, {4'h0, sel[i], 2'b00});
            rd_reg(ADR_CNTL, d);
            repeat (14) @(posedge clk_sys);
            rd_reg(ADR_CNTL, e);
            chk("count step", step[i], e - d);
        end
        $display("Test prescaler done");
        // External clock stands still, so the counter is frozen between bursts
        wr_reg(ADR_CR2, 8'h8D);
        wr_reg(ADR_CR1, 8'h01);
        get_cnt(c);
        wr_cmp(ADR_OC1H, c + 16'h0002);
        ext_ticks(2);
        chk("pin on match", 8'h03, {6'h00, oe_q[0], pin_q[0]});
        ext_ticks(1);
        rd_reg(ADR_OC1L, d);
        rd_reg(ADR_SR, d);
        chk("flag kept", 8'h40, d & SR_MASK);
        rd_reg(ADR_OC1L, d);
        rd_reg(ADR_SR, d);
        chk("flag cleared", 8'h00, d & SR_MASK);
        $display("Test compare and clear done");
        wr_reg(ADR_CR2, 8'h0D);
        wr_reg(ADR_CR1, 8'h00);
        get_cnt(c);
        t = c + 16'h0001;
        wr_cmp(ADR_OC1H, t);
        wr_reg(ADR_OC1H, t[15:8]);
        ext_ticks(1);
        rd_reg(ADR_SR, d);
        chk("match inhibited", 8'h00, d & SR_MASK);
        wr_reg(ADR_OC1L, t[7:0]);
        repeat (2) @(posedge clk_sys);
        rd_reg(ADR_SR, d);
        chk("flag with pin off", 8'h40, d & SR_MASK);
        chk("pin frozen off", 8'h01, {6'h00, oe_q[0], pin_q[0]});
        ext_ticks(1);
        rd_reg(ADR_OC1L, d);
        $display("Test interlock done");
        wr_reg(ADR_CR2, 8'h8D);
        wr_reg(ADR_CR1, 8'h08);
        repeat (2) @(posedge clk_sys);
        chk("forced level", 8'h02, {6'h00, oe_q[0], pin_q[0]});
        rd_reg(ADR_SR, d);
        chk("no flag on force", 8'h00, d & SR_MASK);
        $display("Test force done");
        // Both mode bits set: pulse-width mode must win
        get_cnt(c);
        wr_cmp(ADR_OC1H, c + 16'h0001);
        wr_cmp(ADR_OC2H, c + 16'h0003);
        wr_reg(ADR_CR1, 8'h81);
        wr_reg(ADR_CR2, 8'hBD);
        wr_reg(ADR_CR1, 8'h89);
        repeat (2) @(posedge clk_sys);
        chk("force ignored", 8'h00, {7'h00, pin_q[0]});
        ext_ticks(2);
        chk("pulse high", 8'h01, {7'h00, pin_q[0]});
        ext_ticks(2);
        chk("pulse low", 8'h00, {7'h00, pin_q[0]});
        get_cnt(c);
        chk("reload high", 8'hFF, c[15:8]);
        chk("reload low", 8'hFC, c[7:0]);
        rd_reg(ADR_SR, d);
        chk("pwm status", 8'h80, d & SR_MASK);
        chk("timer irq", 8'h01, {7'h00, irq_q});
        tcp_pin_model_i.capture_pulse(1'b0);
        rd_reg(ADR_IC1H, d);
        chk("first capture ignored", 8'h00, d);
        tcp_pin_model_i.capture_pulse(1'b1);
        rd_reg(ADR_SR, d);
        chk("second capture", 8'h90, d & SR_MASK);
        rd_reg(ADR_IC2H, d);
        chk("second capture value", 8'hFF, d);
        $display("Test pulse-width mode done");
        // One-pulse only: capture edge starts the pulse, compare match ends it
        wr_cmp(ADR_OC1H, 16'hFFFE);
        wr_reg(ADR_CR2, 8'hAD);
        wr_reg(ADR_CR1, 8'h04);
        tcp_pin_model_i.capture_pulse(1'b0);
        chk("one-pulse start", 8'h01, {7'h00, pin_q[0]});
        wr_reg(ADR_CR1, 8'h0C);
        repeat (2) @(posedge clk_sys);
        chk("force ignored in one-pulse", 8'h01, {7'h00, pin_q[0]});
        ext_ticks(2);
        chk("one-pulse match", 8'h00, {7'h00, pin_q[0]});
        $display("Test one-pulse mode done");
        wrap_up();
    end
endmodule : test_timer16_compare_pwm
